// ===== verilog/tipg_top.sv
// Timer group: counter B, counter C with infrared carrier, pulse
// generator, main timer with prescaler, and watchdog.
// Assumes clk_sys_in is the oscillator and all inputs are synchronous.
//
// Notes on behaviour
// - Timer B upper byte, RW, joins into 16 bits.
// - 8-bit B overflows after 256 minus count ticks.
// - 16-bit B overflows after 65536 minus count ticks.
// - Timer C is readable, writable, cleared on reset.
// - Carrier mode plus IR enable makes C carrier.
// - Up mode C times out after ratio times remainder.
// - Carrier is tick/2/((1+C)*scale).
// - Tick is oscillator or oscillator halved.
// - Low segment lasts (1+low)*low scale ticks.
// - High segment lasts (1+high)*high scale ticks.
// - Low underflow interrupt uses vector 15h.
// - High underflow interrupt uses vector 12h.
// - Scale enables choose 1:1 or selected ratio.
// - Select codes give ratios 1:2 through 1:256.
// - Main prescaler count readable, low n bits valid.
// - Prescaler clears on timer write, select write, resets.
// - Watchdog clear or sleep clears watchdog and prescaler.
// - Internal main timer counts each instruction cycle.
// - External main timer counts selected pin edges.
// - Internal timers stop asleep unless conversion wake.
// - Watchdog runs in sleep; time-out resets device.
// - Infrared disabled holds the output high.
// - Single pulse mode ignores high time.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module tipg_top
(
  // Clock and reset.
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  // Wishbone slave.
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic wb_ack_out,
  output logic [31:0] wb_dat_out,
  // Core events and pins.
  input wire logic main_timer_pin_in,
  input wire logic wdt_tick_in,
  input wire logic watchdog_clear_instruction_in,
  input wire logic sleep_instruction_in,
  input wire logic sleep_mode_in,
  input wire logic conversion_busy_in,
  input wire logic conversion_wake_enable_in,
  // Outputs.
  output logic infrared_output_pin_out,
  output logic irq_req_out,
  output logic [7:0] irq_vector_out,
  output logic wdt_reset_out
);
  import tipg_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] div;
    logic [7:0] tb_lo;
    logic [7:0] tb_hi;
    logic [7:0] tc;
    logic [7:0] tc_ps;
    logic [7:0] car_cnt;
    logic carrier;
    logic [7:0] lo_time;
    logic [7:0] hi_time;
    logic [7:0] scale;
    logic [7:0] tc_scale;
    logic [7:0] psc;
    logic [7:0] mtimer;
    logic [7:0] mctl;
    logic [7:0] cfg;
    logic [7:0] status;
    logic [7:0] seg_cnt;
    logic [7:0] seg_ps;
    tipg_pg_t pg;
    logic pin_prev;
    logic [7:0] wdt_ctl;
    logic [7:0] wdt_ps;
    logic [7:0] wdt_cnt;
    logic ack;
    logic [7:0] rdata;
    logic ir_out;
    logic irq;
    logic [7:0] vec;
    logic wdt_rst;
  } tipg_state_t;

  localparam tipg_state_t ST_RST = '{ir_out: 1'b1, pg: PG_IDLE,
                                     default: '0};

  tipg_state_t s_reg;
  tipg_state_t s_next;

  logic wr_en;
  logic rd_en;
  logic run;
  logic ft_tick;
  logic inst_tick;
  logic ir_mode;
  logic mt_ev;
  logic [7:0] set_bits;
  logic [7:0] r_lo;
  logic [7:0] r_hi;
  logic [7:0] r_tc;
  logic [7:0] mask;
  logic [7:0] wmask;
  logic [7:0] wd;
  logic wdt_to;

  // Bus strobes; byte lane 0 carries every register.
  assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & ~s_reg.ack
                 & wb_sel_in[0];
  assign rd_en = wb_cyc_in & wb_stb_in & ~wb_we_in & ~s_reg.ack;
  assign wd = wb_dat_in[7:0];

  // Tick generation from the oscillator.
  assign ft_tick = ~s_reg.cfg[CFG_CLK_OPT] | s_reg.div[0];
  assign inst_tick = s_reg.cfg[CFG_CLK_OPT] ? (&s_reg.div)
                                            : s_reg.div[0];
  // Sleep halts internal timers unless conversion wake keeps them.
  assign run = ~sleep_mode_in
               | (conversion_busy_in & conversion_wake_enable_in);
  assign ir_mode = s_reg.cfg[CFG_CARRIER] & s_reg.cfg[CFG_IR_EN];
  assign r_lo = tipg_ratio_m1(s_reg.scale[SCL_LO_EN],
                              s_reg.scale[2:0]);
  assign r_hi = tipg_ratio_m1(s_reg.scale[SCL_HI_EN],
                              s_reg.scale[6:4]);
  assign r_tc = tipg_ratio_m1(s_reg.tc_scale[TCS_EN],
                              s_reg.tc_scale[2:0]);
  assign mask = tipg_ratio_m1(1'b1, s_reg.mctl[2:0]);
  assign wmask = tipg_ratio_m1(1'b1, s_reg.wdt_ctl[2:0]);

  // Main timer event: selected pin edge or instruction cycle.
  assign mt_ev = s_reg.mctl[MCTL_EXT]
    ? (s_reg.mctl[MCTL_FALL] ? (s_reg.pin_prev & ~main_timer_pin_in)
                             : (~s_reg.pin_prev & main_timer_pin_in))
    : (inst_tick & run);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  // Counters advance first; bus writes then override.
  always_comb
  begin
    s_next = s_reg;
    set_bits = 8'h00;
    wdt_to = 1'b0;
    s_next.div = 2'(s_reg.div + 2'b01);
    s_next.pin_prev = main_timer_pin_in;
    s_next.ack = wb_cyc_in & wb_stb_in & ~s_reg.ack;
    s_next.wdt_rst = 1'b0;

    // Timer B, eight or sixteen bits.
    if (ft_tick & run)
    begin
      s_next.tb_lo = 8'(s_reg.tb_lo + 8'h01);
      if (s_reg.cfg[CFG_UPPER_EN] & (&s_reg.tb_lo))
      begin
        s_next.tb_hi = 8'(s_reg.tb_hi + 8'h01);
      end
      if ((&s_reg.tb_lo)
          & (~s_reg.cfg[CFG_UPPER_EN] | (&s_reg.tb_hi)))
      begin
        set_bits[ST_TB] = 1'b1;
      end
    end

    // Timer C: carrier divider or scaled up counter.
    if (ft_tick & run)
    begin
      if (s_reg.tc_ps == r_tc)
      begin
        s_next.tc_ps = 8'h00;
        if (ir_mode)
        begin
          if (s_reg.car_cnt == s_reg.tc)
          begin
            s_next.car_cnt = 8'h00;
            s_next.carrier = ~s_reg.carrier;
          end
          else
          begin
            s_next.car_cnt = 8'(s_reg.car_cnt + 8'h01);
          end
        end
        else
        begin
          s_next.tc = 8'(s_reg.tc + 8'h01);
          set_bits[ST_TC] = &s_reg.tc;
        end
      end
      else
      begin
        s_next.tc_ps = 8'(s_reg.tc_ps + 8'h01);
      end
    end

    // Pulse generator.
    case (s_reg.pg)
      PG_IDLE:
      begin
        // Start on a tick so the first segment is as long as later ones.
        if (ft_tick & run)
        begin
          s_next.pg = PG_LOW;
          s_next.seg_cnt = s_reg.lo_time;
          s_next.seg_ps = 8'h00;
        end
      end
      PG_LOW:
      begin
        if (ft_tick & run)
        begin
          if (s_reg.seg_ps == r_lo)
          begin
            s_next.seg_ps = 8'h00;
            if (s_reg.seg_cnt == 8'h00)
            begin
              set_bits[ST_LO] = 1'b1;
              if (s_reg.cfg[CFG_SINGLE])
              begin
                s_next.pg = PG_DONE;
              end
              else
              begin
                s_next.pg = PG_HIGH;
                s_next.seg_cnt = s_reg.hi_time;
              end
            end
            else
            begin
              s_next.seg_cnt = 8'(s_reg.seg_cnt - 8'h01);
            end
          end
          else
          begin
            s_next.seg_ps = 8'(s_reg.seg_ps + 8'h01);
          end
        end
      end
      PG_HIGH:
      begin
        if (ft_tick & run)
        begin
          if (s_reg.seg_ps == r_hi)
          begin
            s_next.seg_ps = 8'h00;
            if (s_reg.seg_cnt == 8'h00)
            begin
              set_bits[ST_HI] = 1'b1;
              s_next.pg = PG_LOW;
              s_next.seg_cnt = s_reg.lo_time;
            end
            else
            begin
              s_next.seg_cnt = 8'(s_reg.seg_cnt - 8'h01);
            end
          end
          else
          begin
            s_next.seg_ps = 8'(s_reg.seg_ps + 8'h01);
          end
        end
      end
      PG_DONE:
      begin
        s_next.pg = PG_DONE;
      end
      default:
      begin
        s_next.pg = PG_IDLE;
      end
    endcase
    if (~s_reg.cfg[CFG_IR_EN])
    begin
      s_next.pg = PG_IDLE;
    end

    // Output pin: high unless in a low segment.
    if (~s_reg.cfg[CFG_IR_EN] || s_reg.pg != PG_LOW)
    begin
      s_next.ir_out = 1'b1;
    end
    else
    begin
      s_next.ir_out = s_reg.cfg[CFG_CARRIER] & s_reg.carrier;
    end

    // Main timer with optional prescaler.
    if (mt_ev)
    begin
      if (s_reg.mctl[MCTL_PS_EN])
      begin
        s_next.psc = 8'(s_reg.psc + 8'h01);
        if ((s_reg.psc & mask) == mask)
        begin
          s_next.mtimer = 8'(s_reg.mtimer + 8'h01);
          set_bits[ST_MT] = &s_reg.mtimer;
        end
      end
      else
      begin
        s_next.mtimer = 8'(s_reg.mtimer + 8'h01);
        set_bits[ST_MT] = &s_reg.mtimer;
      end
    end

    // Watchdog counts on its own tick, asleep or not.
    if (s_reg.wdt_ctl[WDT_EN] & wdt_tick_in)
    begin
      if (~s_reg.wdt_ctl[WDT_PS_EN] || (s_reg.wdt_ps & wmask) == wmask)
      begin
        s_next.wdt_cnt = 8'(s_reg.wdt_cnt + 8'h01);
        wdt_to = &s_reg.wdt_cnt;
      end
      if (s_reg.wdt_ctl[WDT_PS_EN])
      begin
        s_next.wdt_ps = 8'(s_reg.wdt_ps + 8'h01);
      end
    end
    if (watchdog_clear_instruction_in | sleep_instruction_in)
    begin
      s_next.wdt_cnt = 8'h00;
      s_next.wdt_ps = 8'h00;
    end

    // Interrupt request and vector, low segment first.
    s_next.irq = (s_reg.status[ST_LO] & s_reg.cfg[CFG_LO_IE])
               | (s_reg.status[ST_HI] & s_reg.cfg[CFG_HI_IE]);
    if (s_reg.status[ST_LO] & s_reg.cfg[CFG_LO_IE])
    begin
      s_next.vec = VEC_LOW;
    end
    else if (s_reg.status[ST_HI] & s_reg.cfg[CFG_HI_IE])
    begin
      s_next.vec = VEC_HIGH;
    end
    else
    begin
      s_next.vec = 8'h00;
    end

    // Read data capture; unmapped reads return zero.
    if (rd_en)
    begin
      case (wb_adr_in)
        ADR_TB_LO: s_next.rdata = s_reg.tb_lo;
        ADR_TB_HI: s_next.rdata = s_reg.tb_hi;
        ADR_TC: s_next.rdata = s_reg.tc;
        ADR_LO_TIME: s_next.rdata = s_reg.lo_time;
        ADR_HI_TIME: s_next.rdata = s_reg.hi_time;
        ADR_SCALE: s_next.rdata = s_reg.scale;
        ADR_PSC: s_next.rdata = s_reg.psc;
        ADR_MTIMER: s_next.rdata = s_reg.mtimer;
        ADR_MCTL: s_next.rdata = s_reg.mctl;
        ADR_CFG: s_next.rdata = s_reg.cfg;
        ADR_TC_SCALE: s_next.rdata = s_reg.tc_scale;
        ADR_STATUS: s_next.rdata = s_reg.status;
        ADR_WDT_CTL: s_next.rdata = s_reg.wdt_ctl;
        default: s_next.rdata = 8'h00;
      endcase
    end

    // Register writes; status bits clear on one, a set wins.
    s_next.status = s_reg.status;
    if (wr_en)
    begin
      case (wb_adr_in)
        ADR_TB_LO: s_next.tb_lo = wd;
        ADR_TB_HI: s_next.tb_hi = wd;
        ADR_TC: s_next.tc = wd;
        ADR_LO_TIME: s_next.lo_time = wd;
        ADR_HI_TIME: s_next.hi_time = wd;
        ADR_SCALE: s_next.scale = wd;
        ADR_PSC: s_next.psc = wd;
        ADR_MTIMER:
        begin
          s_next.mtimer = wd;
          s_next.psc = 8'h00;
        end
        ADR_MCTL:
        begin
          s_next.mctl = wd;
          s_next.psc = 8'h00;
        end
        ADR_CFG: s_next.cfg = wd;
        ADR_TC_SCALE: s_next.tc_scale = wd;
        ADR_STATUS: s_next.status = s_reg.status & ~wd;
        ADR_WDT_CTL: s_next.wdt_ctl = wd;
        default: s_next.status = s_reg.status;
      endcase
    end
    s_next.status = s_next.status | set_bits;

    // Watchdog time-out acts as a full reset of the block.
    if (wdt_to)
    begin
      s_next = ST_RST;
      s_next.wdt_rst = 1'b1;
      s_next.ack = wb_cyc_in & wb_stb_in & ~s_reg.ack;
    end
  end

  // State register.
  always_ff @(posedge clk_sys_in or posedge sys_rst_in)
  begin
    if (sys_rst_in)
    begin
      s_reg <= ST_RST;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Every output is a field of the state register.
  assign wb_ack_out = s_reg.ack;
  assign wb_dat_out = {24'h000000, s_reg.rdata};
  assign infrared_output_pin_out = s_reg.ir_out;
  assign irq_req_out = s_reg.irq;
  assign irq_vector_out = s_reg.vec;
  assign wdt_reset_out = s_reg.wdt_rst;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_ack_single: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in) s_reg.ack |=> !s_reg.ack)
    else $error("ack stayed high two cycles");

  a_ir_disabled_high: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    !s_reg.cfg[CFG_IR_EN] |=> infrared_output_pin_out)
    else $error("ir output low while disabled");

  a_psc_timer_write: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    wr_en && wb_adr_in == ADR_MTIMER |=> s_reg.psc == 8'h00)
    else $error("prescaler not cleared by timer write");

  a_wdt_clear_cmd: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    watchdog_clear_instruction_in | sleep_instruction_in
    |=> s_reg.wdt_cnt == 8'h00 && s_reg.wdt_ps == 8'h00)
    else $error("watchdog not cleared");

  a_tb_byte_wrap: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    ft_tick && run && !s_reg.cfg[CFG_UPPER_EN] && s_reg.tb_lo == 8'hFF
    && !wdt_to && !(wr_en && wb_adr_in == ADR_TB_LO)
    |=> s_reg.tb_lo == 8'h00 && s_reg.status[ST_TB])
    else $error("timer b byte wrap wrong");

  a_tb_word_carry: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    ft_tick && run && s_reg.cfg[CFG_UPPER_EN] && s_reg.tb_lo == 8'hFF
    && !wdt_to && !wr_en
    |=> s_reg.tb_hi == $past(s_reg.tb_hi) + 8'h01)
    else $error("timer b upper byte missed carry");

  a_sleep_hold: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    !run && !s_reg.mctl[MCTL_EXT] && !wr_en && !wdt_to
    |=> $stable(s_reg.mtimer) && $stable(s_reg.tb_lo))
    else $error("timer moved while asleep");

  a_single_stays: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    s_reg.pg == PG_DONE && s_reg.cfg[CFG_IR_EN] |=> ##1
    infrared_output_pin_out)
    else $error("single pulse output not high");

  a_low_vector: assert property (@(posedge clk_sys_in)
    disable iff (sys_rst_in)
    s_reg.status[ST_LO] && s_reg.cfg[CFG_LO_IE] && !wdt_to
    |=> irq_req_out && irq_vector_out == VEC_LOW)
    else $error("low time vector wrong");

endmodule : tipg_top

`default_nettype wire

// ===== pkg/tipg_pkg.sv
// Constants, types and helpers for the timer and pulse generator block.
// Assumes an 8-bit register set reached over a 32-bit Wishbone bus.
package tipg_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] ADR_TB_LO = 8'h00;
  localparam logic [7:0] ADR_TB_HI = 8'h04;
  localparam logic [7:0] ADR_TC = 8'h08;
  localparam logic [7:0] ADR_LO_TIME = 8'h0C;
  localparam logic [7:0] ADR_HI_TIME = 8'h10;
  localparam logic [7:0] ADR_SCALE = 8'h14;
  localparam logic [7:0] ADR_PSC = 8'h18;
  localparam logic [7:0] ADR_MTIMER = 8'h1C;
  localparam logic [7:0] ADR_MCTL = 8'h20;
  localparam logic [7:0] ADR_CFG = 8'h24;
  localparam logic [7:0] ADR_TC_SCALE = 8'h28;
  localparam logic [7:0] ADR_STATUS = 8'h2C;
  localparam logic [7:0] ADR_WDT_CTL = 8'h30;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CFG_UPPER_EN = 0;
  localparam int CFG_CLK_OPT = 1;
  localparam int CFG_CARRIER = 2;
  localparam int CFG_IR_EN = 3;
  localparam int CFG_SINGLE = 4;
  localparam int CFG_LO_IE = 5;
  localparam int CFG_HI_IE = 6;
  localparam int MCTL_PS_EN = 3;
  localparam int MCTL_EXT = 4;
  localparam int MCTL_FALL = 5;
  localparam int SCL_HI_EN = 7;
  localparam int SCL_LO_EN = 3;
  localparam int TCS_EN = 3;
  localparam int WDT_EN = 7;
  localparam int WDT_PS_EN = 3;
  localparam int ST_TB = 0;
  localparam int ST_TC = 1;
  localparam int ST_MT = 2;
  localparam int ST_LO = 3;
  localparam int ST_HI = 4;

  // ----------------------------------------------------------------
  // Interrupt vectors and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_LOW = 8'h15;
  localparam logic [7:0] VEC_HIGH = 8'h12;
  localparam logic [7:0] REG_RST = 8'h00;

  // Pulse generator states.
  typedef enum logic [1:0] {
    PG_IDLE = 2'b00,
    PG_LOW = 2'b01,
    PG_HIGH = 2'b10,
    PG_DONE = 2'b11
  } tipg_pg_t;

  // Ratio minus one for a scale enable and its three-bit select.
  function automatic logic [7:0] tipg_ratio_m1(input logic en,
                                               input logic [2:0] sel);
    logic [8:0] r;
    r = 9'((9'h002 << sel) - 9'h001);
    tipg_ratio_m1 = en ? r[7:0] : 8'h00;
  endfunction : tipg_ratio_m1

endpackage : tipg_pkg

// ===== tb/tb_timer_ir_pulse_generator.sv
// Self-checking bench for the timer and pulse generator block.
// Assumes tipg_pkg and tipg_top are compiled before this file.
`timescale 1ns/1ps
`default_nettype none

module tb_timer_ir_pulse_generator;
  import tipg_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  typedef struct {logic [7:0] lo; logic [7:0] hi; logic [7:0] m;} tipg_note_t;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0000_0000;
  logic pin = 1'b0;
  logic wtick = 1'b0;
  logic wclr = 1'b0;
  logic slp_ins = 1'b0;
  logic slp = 1'b0;
  logic conv = 1'b0;
  logic ack;
  logic [31:0] rdat;
  logic ir;
  logic irq;
  logic [7:0] vec;
  logic wrst;
  int err_total = 0;
  int checked = 0;
  int cyc_cnt = 0;
  int seg_len = 0;
  int wrst_cnt = 0;
  logic ir_prev = 1'b1;
  tipg_note_t rd_q[$];
  int seg_q[$];
  logic [7:0] regs[4] = '{ADR_TB_HI, ADR_LO_TIME, ADR_HI_TIME, ADR_SCALE};

  // The block under test.
  tipg_top u_dut (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .wb_cyc_in(cyc),
    .wb_stb_in(stb),
    .wb_we_in(we),
    .wb_adr_in(adr),
    .wb_sel_in(4'hF),
    .wb_dat_in(dat),
    .wb_ack_out(ack),
    .wb_dat_out(rdat),
    .main_timer_pin_in(pin),
    .wdt_tick_in(wtick),
    .watchdog_clear_instruction_in(wclr),
    .sleep_instruction_in(slp_ins),
    .sleep_mode_in(slp),
    .conversion_busy_in(conv),
    .conversion_wake_enable_in(conv),
    .infrared_output_pin_out(ir),
    .irq_req_out(irq),
    .irq_vector_out(vec),
    .wdt_reset_out(wrst)
  );

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  // The clock toggles every 20 ns, half of its 40 ns period.
  always #20 clk_sys_in = ~clk_sys_in;

  // A hang is cut short after a fixed number of cycles.
  always @(posedge clk_sys_in)
  begin
    cyc_cnt++;
    if (cyc_cnt == 60000)
    begin
      err_total++;
      complete_run();
    end
  end

  // Prints the counts and the verdict, then stops.
  task automatic complete_run();
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : complete_run

  // Reports one mismatch.
  task automatic fail(input string msg);
    err_total++;
    $display("FAIL %0t %s", $time, msg);
  endtask : fail

  // Compares masked read data against a range.
  task automatic check_rd(input logic [31:0] got, input tipg_note_t n);
    logic [7:0] v;
    v = got[7:0] & n.m;
    checked++;
    if ((got[31:8] === 24'h000000 && v >= n.lo && v <= n.hi) !== 1'b1)
      fail($sformatf("read data %h", got));
  endtask : check_rd

  // Compares a count measured by the bench.
  task automatic check_num(input int got, input int exp);
    checked++;
    if (got != exp)
      fail($sformatf("count %0d expected %0d", got, exp));
  endtask : check_num

  // Compares an output value.
  task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
      fail($sformatf("output %h expected %h", got, exp));
  endtask : check_val

  // ----------------------------------------------------------------
  // Monitors
  // ----------------------------------------------------------------
  // Read data is compared with the oldest note when ack is seen.
  always @(posedge clk_sys_in)
    if (ack === 1'b1 && we === 1'b0 && rd_q.size() > 0)
      check_rd(rdat, rd_q.pop_front());

  // Measures output segments and counts watchdog reset pulses.
  always @(posedge clk_sys_in)
  begin
    if (wrst === 1'b1)
      wrst_cnt++;
    if (ir !== ir_prev)
    begin
      if (seg_q.size() > 0)
        check_num(seg_len, seg_q.pop_front());
      seg_len = 1;
    end
    else
      seg_len++;
    ir_prev = ir;
  end

  // ----------------------------------------------------------------
  // Drivers
  // ----------------------------------------------------------------
  // One classic Wishbone cycle, held until ack is sampled.
  task automatic wb_cycle(input logic w, input logic [7:0] a,
                          input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= {24'h000000, d};
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100)
      fail("no ack");
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb_cycle

  // Notes the expected range, then reads.
  task automatic rd(input logic [7:0] a, input logic [7:0] lo,
                    input logic [7:0] hi, input logic [7:0] m);
    rd_q.push_back('{lo, hi, m});
    wb_cycle(1'b0, a, 8'h00);
  endtask : rd

  // Waits a number of clock cycles.
  task automatic ticks(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask : ticks

  // Pin pulses held four cycles per level, longer than one cycle.
  task automatic pin_pulses(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_in) pin <= 1'b1;
      ticks(3);
      @(posedge clk_sys_in) pin <= 1'b0;
      ticks(3);
    end
  endtask : pin_pulses

  // Watchdog oscillator ticks, one pulse every other cycle.
  task automatic wdt_ticks(input int n);
    repeat (n)
    begin
      @(posedge clk_sys_in) wtick <= 1'b1;
      @(posedge clk_sys_in) wtick <= 1'b0;
    end
  endtask : wdt_ticks

  // Loads a counter, clears status, and checks timeout timing.
  task automatic tmo(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] late);
    wb_cycle(1'b1, a, 8'hF0);
    wb_cycle(1'b1, ADR_STATUS, 8'hFF);
    ticks(2);
    rd(ADR_STATUS, 8'h00, 8'h00, m);
    ticks(10);
    rd(ADR_STATUS, late, late, m);
  endtask : tmo

  // Restarts the generator and measures up to three segments.
  task automatic pulse_run(input logic [7:0] c, input int lw,
                           input int hw, input int nseg);
    int n;
    wb_cycle(1'b1, ADR_CFG, 8'h00);
    wb_cycle(1'b1, ADR_CFG, c);
    n = 0;
    while (ir !== 1'b0 && n < 50)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    // Let the monitor see the falling edge before noting lengths.
    @(negedge clk_sys_in);
    seg_q.push_back(lw);
    if (nseg > 1)
      seg_q.push_back(hw);
    if (nseg > 2)
      seg_q.push_back(lw);
    n = 0;
    while (seg_q.size() > 0 && n < 3000)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    if (seg_q.size() > 0)
      fail("pulse segments missing");
    seg_q.delete();
  endtask : pulse_run

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [7:0] v;
    void'($urandom(63913));
    repeat (5) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    check_val({7'h00, ir}, 8'h01);
    foreach (regs[i])
    begin
      rd(regs[i], 8'h00, 8'h00, 8'hFF);
      v = 8'($urandom);
      wb_cycle(1'b1, regs[i], v);
      rd(regs[i], v, v, 8'hFF);
    end
    rd(8'h3C, 8'h00, 8'h00, 8'hFF);
    wb_cycle(1'b1, ADR_MCTL, 8'h1F);
    wb_cycle(1'b1, ADR_PSC, 8'h5A);
    rd(ADR_PSC, 8'h5A, 8'h5A, 8'hFF);
    wb_cycle(1'b1, ADR_MTIMER, 8'h00);
    rd(ADR_PSC, 8'h00, 8'h00, 8'hFF);
    wb_cycle(1'b1, ADR_PSC, 8'hA5);
    wb_cycle(1'b1, ADR_MCTL, 8'h1F);
    rd(ADR_PSC, 8'h00, 8'h00, 8'hFF);
    wb_cycle(1'b1, ADR_MCTL, 8'h00);
    wb_cycle(1'b1, ADR_MTIMER, 8'h00);
    ticks(40);
    rd(ADR_MTIMER, 8'd19, 8'd23, 8'hFF);
    @(posedge clk_sys_in) slp <= 1'b1;
    wb_cycle(1'b1, ADR_MTIMER, 8'h40);
    ticks(40);
    rd(ADR_MTIMER, 8'h40, 8'h40, 8'hFF);
    @(posedge clk_sys_in) conv <= 1'b1;
    wb_cycle(1'b1, ADR_MTIMER, 8'h00);
    ticks(40);
    rd(ADR_MTIMER, 8'd19, 8'd23, 8'hFF);
    @(posedge clk_sys_in) slp <= 1'b0;
    conv <= 1'b0;
    wb_cycle(1'b1, ADR_MCTL, 8'h08);
    wb_cycle(1'b1, ADR_MTIMER, 8'h00);
    ticks(40);
    rd(ADR_MTIMER, 8'd9, 8'd12, 8'hFF);
    wb_cycle(1'b1, ADR_MCTL, 8'h10);
    wb_cycle(1'b1, ADR_MTIMER, 8'h00);
    pin_pulses(5);
    rd(ADR_MTIMER, 8'h05, 8'h05, 8'hFF);
    wb_cycle(1'b1, ADR_MCTL, 8'h30);
    wb_cycle(1'b1, ADR_MTIMER, 8'h00);
    pin_pulses(3);
    rd(ADR_MTIMER, 8'h03, 8'h03, 8'hFF);
    tmo(ADR_TB_LO, 8'h01, 8'h01);
    wb_cycle(1'b1, ADR_CFG, 8'h01);
    wb_cycle(1'b1, ADR_TB_HI, 8'hFF);
    tmo(ADR_TB_LO, 8'h01, 8'h01);
    wb_cycle(1'b1, ADR_TB_HI, 8'hFE);
    tmo(ADR_TB_LO, 8'h01, 8'h00);
    tmo(ADR_TC, 8'h02, 8'h02);
    wb_cycle(1'b1, ADR_TC_SCALE, 8'h08);
    tmo(ADR_TC, 8'h02, 8'h00);
    wb_cycle(1'b1, ADR_CFG, 8'h0C);
    wb_cycle(1'b1, ADR_TC, 8'h33);
    ticks(20);
    rd(ADR_TC, 8'h33, 8'h33, 8'hFF);
    wb_cycle(1'b1, ADR_LO_TIME, 8'h01);
    wb_cycle(1'b1, ADR_HI_TIME, 8'h01);
    for (int s = 0; s < 8; s++)
    begin
      wb_cycle(1'b1, ADR_SCALE, 8'h08 | 8'(s));
      pulse_run(8'h08, 2 << (s + 1), 2, 3);
    end
    wb_cycle(1'b1, ADR_SCALE, 8'hA0);
    pulse_run(8'h08, 2, 16, 3);
    wb_cycle(1'b1, ADR_SCALE, 8'h00);
    wb_cycle(1'b1, ADR_LO_TIME, 8'h02);
    wb_cycle(1'b1, ADR_HI_TIME, 8'h04);
    pulse_run(8'h0A, 6, 10, 3);
    pulse_run(8'h38, 3, 0, 1);
    ticks(40);
    check_val({7'h00, ir}, 8'h01);
    check_val({7'h00, irq}, 8'h01);
    check_val(vec, VEC_LOW);
    wb_cycle(1'b1, ADR_STATUS, 8'h18);
    ticks(3);
    check_val({7'h00, irq}, 8'h00);
    pulse_run(8'h48, 3, 5, 3);
    check_val({7'h00, irq}, 8'h01);
    check_val(vec, VEC_HIGH);
    wb_cycle(1'b1, ADR_CFG, 8'h00);
    ticks(3);
    check_val({7'h00, ir}, 8'h01);
    wb_cycle(1'b1, ADR_TB_HI, 8'h77);
    wb_cycle(1'b1, ADR_WDT_CTL, 8'h80);
    wdt_ticks(200);
    @(posedge clk_sys_in) wclr <= 1'b1;
    @(posedge clk_sys_in) wclr <= 1'b0;
    wdt_ticks(255);
    check_num(wrst_cnt, 0);
    @(posedge clk_sys_in) slp_ins <= 1'b1;
    @(posedge clk_sys_in) slp_ins <= 1'b0;
    slp <= 1'b1;
    wdt_ticks(255);
    check_num(wrst_cnt, 0);
    wdt_ticks(1);
    ticks(3);
    check_num(wrst_cnt, 1);
    @(posedge clk_sys_in) slp <= 1'b0;
    rd(ADR_TB_HI, 8'h00, 8'h00, 8'hFF);
    rd(ADR_WDT_CTL, 8'h00, 8'h00, 8'hFF);
    ticks(3);
    complete_run();
  end

endmodule : tb_timer_ir_pulse_generator

`default_nettype wire
